/* crc_engine_data_ports_tb.sv */
// self-checking bench of the crc engine data ports
`timescale 1ns/1ns
`include "crce_consts.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
   failures++; $display("BAD t=%0t got=%0h exp=%0h", $time, g, e); end end
module crc_engine_data_ports_tb import crce_pkg::*;;
   logic mclk, rst, clk_en, code_fetch, code_byte_undefined, auto_start;
   crce_sfr_req_t sfr_req;
   logic [7:0] code_byte_in, sfr_rdata, code_byte_out, q, b;
   logic [5:0] auto_start_sector;
   logic [31:0] crc_result, ex;
   logic st;
   int failures = 0;
   int checks_done = 0;
   crce_data_ports i_dut (.mclk(mclk), .rst(rst), .clk_en(clk_en),
      .sfr_req(sfr_req), .code_fetch(code_fetch),
      .code_byte_in(code_byte_in), .sfr_rdata(sfr_rdata),
      .code_byte_out(code_byte_out),
      .code_byte_undefined(code_byte_undefined),
      .auto_start(auto_start), .auto_start_sector(auto_start_sector),
      .crc_result(crc_result));
   crce_core_model i_core (.mclk(mclk), .sfr_req(sfr_req),
      .code_fetch(code_fetch), .code_byte_in(code_byte_in),
      .sfr_rdata(sfr_rdata), .auto_start(auto_start),
      .code_byte_undefined(code_byte_undefined),
      .code_byte_out(code_byte_out));
   // ==========================================================
   // helpers
   function automatic logic [31:0] ref_fold(input logic [31:0] c,
         input logic [7:0] d, input logic h);
      logic fb;
      for (int i = 7; i >= 0; i--) begin
         fb = (h ? c[15] : c[31]) ^ d[i];
         if (h) begin
            c = {16'h0000, c[14:0], 1'b0} ^ (fb ? {16'h0000, `CRCE_POLY16} : '0);
         end else begin
            c = {c[30:0], 1'b0} ^ (fb ? `CRCE_POLY32 : 32'h00000000);
         end
      end
      return c;
   endfunction
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      i_core.acc(1'b1, a, d, q, st);
   endtask
   task automatic rd(input logic [7:0] a);
      i_core.acc(1'b0, a, 8'h00, q, st);
   endtask
   task automatic wrap_up;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // ==========================================================
   // scenarios
   task automatic t_reset;
      `CHK(crc_result, `CRCE_RESET_RESULT)
      rd(`CRCE_ADDR_BYTE_INPUT);
      `CHK(q, `CRCE_RESET_BYTE)
      rd(8'h90);
      `CHK(q, 8'h00)
      @(posedge mclk) clk_en <= 1'b0;
      wr(`CRCE_ADDR_BYTE_INPUT, 8'h3C);
      @(posedge mclk) clk_en <= 1'b1;
      `CHK(crc_result, 32'h00000000)
   endtask
   task automatic t_fold32;
      wr(`CRCE_ADDR_CONTROL, 8'h0C);
      `CHK(crc_result, `CRCE_INIT_ONES)
      ex = `CRCE_INIT_ONES;
      for (int i = 0; i < 3; i++) begin
         b = 8'h31 + 8'(i);
         wr(`CRCE_ADDR_BYTE_INPUT, b);
         ex = ref_fold(ex, b, 1'b0);
         `CHK(crc_result, ex)
      end
      rd(`CRCE_ADDR_BYTE_INPUT);
      `CHK(q, 8'h33)
      for (int i = 0; i < 5; i++) begin
         rd(`CRCE_ADDR_RESULT_PORT);
         `CHK(q, ex[8 * (i % 4) +: 8])
      end
   endtask
   task automatic t_port_write;
      wr(`CRCE_ADDR_CONTROL, 8'h0A);
      `CHK(crc_result, 32'h00000000)
      wr(`CRCE_ADDR_RESULT_PORT, 8'hA5);
      wr(`CRCE_ADDR_RESULT_PORT, 8'h5A);
      wr(`CRCE_ADDR_RESULT_PORT, 8'hC3);
      `CHK(crc_result, 32'h5AA500C3)
      rd(`CRCE_ADDR_RESULT_PORT);
      `CHK(q, 8'h00)
      rd(`CRCE_ADDR_RESULT_PORT);
      `CHK(q, 8'hA5)
   endtask
   task automatic t_fold16;
      wr(`CRCE_ADDR_CONTROL, 8'h1C);
      `CHK(crc_result, `CRCE_INIT_ONES)
      rd(`CRCE_ADDR_CONTROL);
      `CHK(q, 8'h14)
      ex = ref_fold(`CRCE_INIT_ONES, 8'h31, 1'b1);
      wr(`CRCE_ADDR_BYTE_INPUT, 8'h31);
      `CHK(crc_result[15:0], ex[15:0])
      for (int i = 0; i < 4; i++) begin
         rd(`CRCE_ADDR_RESULT_PORT);
         `CHK(q, ex[8 * (i % 2) +: 8])
      end
   endtask
   task automatic t_auto;
      logic [2:0] u;
      logic [23:0] o;
      wr(`CRCE_ADDR_AUTO, 8'h85);
      `CHK(st, 1'b0)
      rd(`CRCE_ADDR_AUTO);
      `CHK(q, 8'hC5)
      wr(`CRCE_ADDR_CONTROL, 8'h00);
      `CHK(st, 1'b1)
      `CHK(auto_start_sector, 6'h05)
      i_core.mov_flip(u, o);
      `CHK(u, 3'b100)
      `CHK(o, 24'hFF9575)
      i_core.fetch(8'hE4, u[0], o[7:0]);
      `CHK(u[0], 1'b0)
      `CHK(o[7:0], 8'hE4)
      wr(`CRCE_ADDR_AUTO, 8'h05);
      wr(`CRCE_ADDR_CONTROL, 8'h00);
      `CHK(st, 1'b0)
   endtask
   // ==========================================================
   // clock, reset, sequence
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   initial begin
      repeat (5000) @(posedge mclk);
      failures++;
      wrap_up();
   end
   initial begin
      rst = 1'b1;
      clk_en = 1'b1;
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      t_reset();
      t_fold32();
      t_port_write();
      t_fold16();
      t_auto();
      wrap_up();
   end
endmodule // crc_engine_data_ports_tb

/* crce_byte_fold.sv */
// one-byte msb-first crc update for the 32-bit or 16-bit generator
`timescale 1ns/1ns
module crce_byte_fold import crce_pkg::*; #(
   parameter int WIDTH = 32
) (
   input wire logic [31:0] crc_in,
   input wire logic [7:0] data_in,
   input wire logic poly16,
   output logic [31:0] crc_out
);
`include "crce_consts.svh"
   // the fold is written for the 32-bit result register only
   if (WIDTH != 32) begin : g_width_check
      $error("crce_byte_fold serves only 32 bits");
   end
   // ==========================================================
   // shift-and-xor, eight steps unrolled by a loop
   always_comb begin
      logic [31:0] c;
      logic fb;
      c = crc_in;
      fb = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         if (poly16) begin
            fb = c[15] ^ data_in[i];
            c = {16'h0000, c[14:0], 1'b0} ^
               (fb ? {16'h0000, `CRCE_POLY16} : 32'h00000000);
         end else begin
            fb = c[31] ^ data_in[i];
            c = {c[30:0], 1'b0} ^ (fb ? `CRCE_POLY32 : 32'h00000000);
         end
      end
      crc_out = c;
   end
endmodule // crce_byte_fold

/* crce_consts.svh */
// constants of the crc engine data ports: sfr addresses, fields, reset values
`ifndef CRCE_CONSTS_SVH
`define CRCE_CONSTS_SVH
`define CRCE_ADDR_RESULT_PORT 8'h91
`define CRCE_ADDR_BYTE_INPUT 8'h93
`define CRCE_ADDR_CONTROL 8'h92
`define CRCE_ADDR_AUTO 8'h96
`define CRCE_CTL_POLY_BIT 4
`define CRCE_CTL_INIT_BIT 3
`define CRCE_CTL_VAL_BIT 2
`define CRCE_AUTO_EN_BIT 7
`define CRCE_AUTO_DONE_BIT 6
`define CRCE_POLY32 32'h04C11DB7
`define CRCE_POLY16 16'h1021
`define CRCE_RESET_BYTE 8'h00
`define CRCE_RESET_RESULT 32'h00000000
`define CRCE_INIT_ONES 32'hFFFFFFFF
`define CRCE_FETCH_HAZARD_SLOT 2'h3
`endif

/* crce_core_model.sv */
// core-side model: sfr accesses and code byte fetches
`timescale 1ns/1ns
module crce_core_model import crce_pkg::*; (
   input wire logic mclk,
   output crce_sfr_req_t sfr_req,
   output logic code_fetch,
   output logic [7:0] code_byte_in,
   input wire logic [7:0] sfr_rdata,
   input wire logic auto_start,
   input wire logic code_byte_undefined,
   input wire logic [7:0] code_byte_out
);
   initial begin
      sfr_req = '0;
      code_fetch = 1'b0;
      code_byte_in = 8'h00;
   end
   // ==========================================================
   // sfr access
   // released lines show the inverse so a stale value never matches
   task automatic acc(input logic w, input logic [7:0] a,
         input logic [7:0] d, output logic [7:0] q, output logic st);
      @(posedge mclk);
      sfr_req <= '{wr: w, rd: !w, addr: a, wdata: d};
      @(posedge mclk);
      st = auto_start;
      sfr_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
      #1 q = sfr_rdata;
   endtask
   // ==========================================================
   // code fetch
   task automatic fetch(input logic [7:0] b, output logic u,
         output logic [7:0] o);
      @(posedge mclk);
      code_fetch <= 1'b1;
      code_byte_in <= b;
      @(posedge mclk);
      u = code_byte_undefined;
      o = code_byte_out;
      code_fetch <= 1'b0;
      code_byte_in <= ~b;
   endtask
   // harmless 3-byte move to the bit-reverse register after a start
   task automatic mov_flip(output logic [2:0] u, output logic [23:0] o);
      fetch(8'h75, u[0], o[7:0]);
      fetch(8'h95, u[1], o[15:8]);
      // non-zero dummy keeps the long move form
      fetch(8'h5A, u[2], o[23:16]);
   endtask
endmodule // crce_core_model

/* crce_data_ports.sv */
// crc engine data ports: input byte fold, result byte port, control
// ==========================================================
// Overview of operation
// - pointer steps by one, wrapping, on each result port read or write
// - 32-bit mode: pointer 0..3 picks result bytes 0..3
// - 16-bit mode: pointers 00/10 pick low byte, 01/11 high byte
// - third opcode byte fetched after auto start may be undefined
// - each input byte write folds into the result; register readable
// - result port reads pointed byte, writes replace exactly that byte
// - polynomial select: clear 32-bit 0x04C11DB7, set 16-bit 0x1021
// - init strobe loads zeros or ones by value select
// - with auto enable set, any control write starts an auto crc
`timescale 1ns/1ns
module crce_data_ports import crce_pkg::*; (
   input wire logic mclk,
   input wire logic rst,
   input wire logic clk_en,
   input wire crce_sfr_req_t sfr_req,
   input wire logic code_fetch,
   input wire logic [7:0] code_byte_in,
   output logic [7:0] sfr_rdata,
   output logic [7:0] code_byte_out,
   output logic code_byte_undefined,
   output logic auto_start,
   output logic [5:0] auto_start_sector,
   output logic [31:0] crc_result
);
`include "crce_consts.svh"
   crce_state_struct_t s_reg;
   crce_state_struct_t s_next;
   logic [31:0] folded;
   logic [7:0] sel_byte;
   logic [4:0] sel_shift;
   logic ctl_wr;
   // ==========================================================
   // datapath
   crce_byte_fold #(.WIDTH(32)) u_fold (
      .crc_in(s_reg.result_reg),
      .data_in(sfr_req.wdata),
      .poly16(s_reg.polynomial_width_select_reg),
      .crc_out(folded)
   );
   always_comb begin
      // 16-bit mode ignores pointer bit 1
      if (s_reg.polynomial_width_select_reg) begin
         sel_shift = {1'b0, s_reg.result_byte_pointer_reg[0], 3'b000};
      end else begin
         sel_shift = {s_reg.result_byte_pointer_reg, 3'b000};
      end
      sel_byte = 8'(s_reg.result_reg >> sel_shift);
   end
   assign ctl_wr = sfr_req.wr && (sfr_req.addr == `CRCE_ADDR_CONTROL);
   // ==========================================================
   // next-state logic
   always_comb begin
      s_next = s_reg;
      if (sfr_req.rd || sfr_req.wr) begin
         case (sfr_req.addr)
            `CRCE_ADDR_RESULT_PORT: s_next.rdata_reg = sel_byte;
            `CRCE_ADDR_BYTE_INPUT: s_next.rdata_reg = s_reg.crc_byte_input_reg;
            `CRCE_ADDR_CONTROL: s_next.rdata_reg = {3'b000,
               s_reg.polynomial_width_select_reg, 1'b0,
               s_reg.init_value_select_reg, s_reg.result_byte_pointer_reg};
            `CRCE_ADDR_AUTO: s_next.rdata_reg =
               {s_reg.auto_sector_check_enable_reg, 1'b1,
                s_reg.start_sector_reg};
            default: s_next.rdata_reg = `CRCE_RESET_BYTE;
         endcase
      end
      if (sfr_req.addr == `CRCE_ADDR_RESULT_PORT &&
          (sfr_req.rd || sfr_req.wr)) begin
         s_next.result_byte_pointer_reg =
            s_reg.result_byte_pointer_reg + 2'h1;
      end
      if (sfr_req.wr) begin
         case (sfr_req.addr)
            `CRCE_ADDR_RESULT_PORT: begin
               s_next.result_reg = s_reg.result_reg &
                  ~(32'h000000FF << sel_shift);
               s_next.result_reg = s_next.result_reg |
                  ({24'h000000, sfr_req.wdata} << sel_shift);
            end
            `CRCE_ADDR_BYTE_INPUT: begin
               s_next.crc_byte_input_reg = sfr_req.wdata;
               s_next.result_reg = folded;
            end
            `CRCE_ADDR_CONTROL: begin
               s_next.polynomial_width_select_reg =
                  sfr_req.wdata[`CRCE_CTL_POLY_BIT];
               s_next.init_value_select_reg = sfr_req.wdata[`CRCE_CTL_VAL_BIT];
               s_next.result_byte_pointer_reg = sfr_req.wdata[1:0];
               if (sfr_req.wdata[`CRCE_CTL_INIT_BIT]) begin
                  // the value bit of this same write decides
                  s_next.result_reg = sfr_req.wdata[`CRCE_CTL_VAL_BIT] ?
                     `CRCE_INIT_ONES : `CRCE_RESET_RESULT;
               end
            end
            `CRCE_ADDR_AUTO: begin
               s_next.auto_sector_check_enable_reg =
                  sfr_req.wdata[`CRCE_AUTO_EN_BIT];
               s_next.start_sector_reg = sfr_req.wdata[5:0];
            end
            default: s_next.rdata_reg = `CRCE_RESET_BYTE;
         endcase
      end
      // fetch hazard tracker: the third fetched byte after an auto start
      case (s_reg.state_reg)
         CRCE_IDLE: begin
            if (ctl_wr && s_reg.auto_sector_check_enable_reg) begin
               s_next.state_reg = CRCE_AUTO_START;
               s_next.fetch_count_reg = 2'h0;
            end
         end
         CRCE_AUTO_START: begin
            if (code_fetch) begin
               s_next.fetch_count_reg = s_reg.fetch_count_reg + 2'h1;
               if (s_reg.fetch_count_reg ==
                   `CRCE_FETCH_HAZARD_SLOT - 2'h1) begin
                  s_next.state_reg = CRCE_IDLE;
               end
            end
         end
         default: s_next.state_reg = CRCE_IDLE;
      endcase
   end
   // ==========================================================
   // state register
   always_ff @(posedge mclk) begin
      if (rst) begin
         s_reg <= '{result_reg: `CRCE_RESET_RESULT,
            result_byte_pointer_reg: 2'h0,
            polynomial_width_select_reg: 1'b0,
            init_value_select_reg: 1'b0,
            auto_sector_check_enable_reg: 1'b0,
            start_sector_reg: 6'h00,
            crc_byte_input_reg: `CRCE_RESET_BYTE,
            rdata_reg: `CRCE_RESET_BYTE,
            fetch_count_reg: 2'h0,
            state_reg: CRCE_IDLE};
      end else if (clk_en) begin
         s_reg <= s_next;
      end
   end
   // ==========================================================
   // outputs
   // the hazard byte is replaced by 0xFF and marked undefined;
   // software keeps it harmless by placing a dummy 3-byte move there
   assign code_byte_undefined = (s_reg.state_reg == CRCE_AUTO_START) &&
      code_fetch &&
      (s_reg.fetch_count_reg == `CRCE_FETCH_HAZARD_SLOT - 2'h1);
   assign code_byte_out = code_byte_undefined ? 8'hFF : code_byte_in;
   assign auto_start = ctl_wr && clk_en && s_reg.auto_sector_check_enable_reg;
   assign auto_start_sector = s_reg.start_sector_reg;
   assign sfr_rdata = s_reg.rdata_reg;
   assign crc_result = s_reg.result_reg;
   // ==========================================================
   // assertions
   property p_ptr_step;
      @(posedge mclk) disable iff (rst)
      clk_en && (sfr_req.rd || sfr_req.wr) &&
      sfr_req.addr == `CRCE_ADDR_RESULT_PORT |=>
      s_reg.result_byte_pointer_reg ==
      $past(s_reg.result_byte_pointer_reg) + 2'h1;
   endproperty
   a_ptr_step: assert property (p_ptr_step)
      else $error("pointer did not step");
   property p_read32;
      @(posedge mclk) disable iff (rst)
      clk_en && sfr_req.rd && !s_reg.polynomial_width_select_reg &&
      sfr_req.addr == `CRCE_ADDR_RESULT_PORT |=>
      sfr_rdata == 8'($past(s_reg.result_reg) >>
      {$past(s_reg.result_byte_pointer_reg), 3'b000});
   endproperty
   a_read32: assert property (p_read32)
      else $error("wrong 32-bit result byte");
   property p_read16;
      @(posedge mclk) disable iff (rst)
      clk_en && sfr_req.rd && s_reg.polynomial_width_select_reg &&
      sfr_req.addr == `CRCE_ADDR_RESULT_PORT |=>
      sfr_rdata == ($past(s_reg.result_byte_pointer_reg[0]) ?
      $past(s_reg.result_reg[15:8]) : $past(s_reg.result_reg[7:0]));
   endproperty
   a_read16: assert property (p_read16)
      else $error("wrong 16-bit result byte");
   property p_fold;
      @(posedge mclk) disable iff (rst)
      clk_en && sfr_req.wr && sfr_req.addr == `CRCE_ADDR_BYTE_INPUT |=>
      crc_result == $past(folded) &&
      s_reg.crc_byte_input_reg == $past(sfr_req.wdata);
   endproperty
   a_fold: assert property (p_fold)
      else $error("input byte not folded");
   property p_init;
      @(posedge mclk) disable iff (rst)
      clk_en && ctl_wr && sfr_req.wdata[`CRCE_CTL_INIT_BIT] |=>
      crc_result == ($past(sfr_req.wdata[`CRCE_CTL_VAL_BIT]) ?
      `CRCE_INIT_ONES : `CRCE_RESET_RESULT);
   endproperty
   a_init: assert property (p_init)
      else $error("init value wrong");
   property p_poly;
      @(posedge mclk) disable iff (rst)
      clk_en && ctl_wr |=> s_reg.polynomial_width_select_reg ==
      $past(sfr_req.wdata[`CRCE_CTL_POLY_BIT]);
   endproperty
   a_poly: assert property (p_poly)
      else $error("polynomial select not taken");
   property p_auto;
      @(posedge mclk) disable iff (rst)
      clk_en && ctl_wr && s_reg.auto_sector_check_enable_reg |->
      auto_start ##1 s_reg.state_reg == CRCE_AUTO_START;
   endproperty
   a_auto: assert property (p_auto)
      else $error("auto crc not started");
   property p_port_wr;
      @(posedge mclk) disable iff (rst)
      clk_en && sfr_req.wr && !s_reg.polynomial_width_select_reg &&
      sfr_req.addr == `CRCE_ADDR_RESULT_PORT &&
      s_reg.result_byte_pointer_reg == 2'h0 |=>
      crc_result == {$past(s_reg.result_reg[31:8]), $past(sfr_req.wdata)};
   endproperty
   a_port_wr: assert property (p_port_wr)
      else $error("result byte write wrong");
   c_fold: cover property (@(posedge mclk) disable iff (rst)
      clk_en && sfr_req.wr && sfr_req.addr == `CRCE_ADDR_BYTE_INPUT);
   c_read16: cover property (@(posedge mclk) disable iff (rst)
      clk_en && sfr_req.rd && s_reg.polynomial_width_select_reg);
   c_hazard: cover property (@(posedge mclk) disable iff (rst)
      code_byte_undefined);
endmodule // crce_data_ports

/* crce_pkg.sv */
// types of the crc engine data ports
package crce_pkg;
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } crce_sfr_req_t;
   typedef enum logic [0:0] {
      CRCE_IDLE,
      CRCE_AUTO_START
   } crce_state_t;
   typedef struct packed {
      logic [31:0] result_reg;
      logic [1:0] result_byte_pointer_reg;
      logic polynomial_width_select_reg;
      logic init_value_select_reg;
      logic auto_sector_check_enable_reg;
      logic [5:0] start_sector_reg;
      logic [7:0] crc_byte_input_reg;
      logic [7:0] rdata_reg;
      logic [1:0] fetch_count_reg;
      crce_state_t state_reg;
   } crce_state_struct_t;
endpackage
